/* src/power_and_init_word_loader.sv */
// Purpose: Loads the power word and init word into live settings
// Assumes: Internal memory flags each word as programmed or blank
// Notes: Loads once after reset; software may ask for a reload
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Selector 0 or 4 reports the active-state power byte, bits 15:8, in 100 mW units.
// - Selector 8 reports the shared-function power field, bits 7:5.
// - Selector 3 or 7 reports the low-power-state field, bits 4:0, in 100 mW units.
// - Narrow power fields are reported with zeros in the upper bits.
// - Init bit 13 sets the default of the loss-of-signal inversion bit.
// - Init bit 10 goes to both the control and wake control advanced wake enables.
// - Init bit 9, default 1, loads the automatic crossover enable.
// - With crossover enabled the device decides itself on swapping cable pairs.
// - Init bit 7, default 1, disables the expansion ROM base address register.
// - Init bit 6 at 0 limits advanced wake to low power; at 1 it acts whenever enabled.
// - The wake-in-active-state bit is copied into the wake control register at load.
// - Init bits 5:4 load the link mode; 00 selects the internal copper PHY.
module power_and_init_word_loader (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    output logic mem_rd_out,
    output logic [7:0] mem_addr_out,
    input wire logic [15:0] mem_data_in,
    input wire logic mem_valid_in,
    input wire logic [3:0] data_select_in,
    output logic [7:0] power_data_out,
    input wire logic low_power_state_in,
    input wire logic wake_event_in,
    input wire logic pairs_swapped_in,
    output logic loss_signal_invert_out,
    output logic ctrl_advanced_wake_out,
    output logic advanced_wake_enable_out,
    output logic wake_in_active_state_enable_out,
    output logic auto_crossover_out,
    output logic crossover_swap_out,
    output logic rom_bar_disable_out,
    output logic [1:0] link_mode_out,
    output logic wake_request_out,
    output logic load_done_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Two stages so release is clean against the clock
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_POWER = 3'b001,
        ST_POWER_WAIT = 3'b010,
        ST_INIT = 3'b011,
        ST_INIT_WAIT = 3'b100,
        ST_DONE = 3'b101
    } load_state_type;

    typedef struct packed {
        load_state_type fsm;
        logic start;
        logic [7:0] addr;
        logic [15:0] power_word;
        logic los_inv;
        logic ctrl_wake;
        logic wuc_wake;
        logic wake_d0;
        logic auto_cross;
        logic swap;
        logic rom_dis;
        logic [1:0] link_mode;
        logic wake_req;
        logic done;
        logic [15:0] rdata;
    } loader_state_type;

    loader_state_type state_q;
    loader_state_type state_d;

    logic fetch_done;
    logic [15:0] fetch_word;
    logic fetch_valid;

    // Wake qualifier: enable set, and either the active-state option or low power
    function automatic logic wake_allowed(input logic en, input logic d0, input logic lp);
        wake_allowed = en && (d0 || lp);
    endfunction : wake_allowed

    // ----------------------------------------------------------------
    // Sequencer and live settings
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.start = 1'b0;
        state_d.rdata = 16'h0000;
        case (state_q.fsm)
            ST_IDLE: begin
                state_d.fsm = ST_POWER;
            end
            ST_POWER: begin
                state_d.start = 1'b1;
                state_d.addr = loader_pkg::POWER_WORD_ADDR;
                state_d.fsm = ST_POWER_WAIT;
            end
            ST_POWER_WAIT: begin
                if (fetch_done) begin
                    if (fetch_valid) begin
                        state_d.power_word = fetch_word;
                    end
                    state_d.fsm = ST_INIT;
                end
            end
            ST_INIT: begin
                state_d.start = 1'b1;
                state_d.addr = loader_pkg::INIT_WORD_ADDR;
                state_d.fsm = ST_INIT_WAIT;
            end
            ST_INIT_WAIT: begin
                if (fetch_done) begin
                    // Blank word leaves current settings (defaults after reset); reserved bits never looked at
                    if (fetch_valid) begin
                        state_d.los_inv = fetch_word[loader_pkg::LOS_INVERT_BIT];
                        state_d.ctrl_wake = fetch_word[loader_pkg::ADV_WAKE_BIT];
                        state_d.wuc_wake = fetch_word[loader_pkg::ADV_WAKE_BIT];
                        state_d.auto_cross = fetch_word[loader_pkg::AUTO_CROSS_BIT];
                        state_d.rom_dis = fetch_word[loader_pkg::ROM_DISABLE_BIT];
                        state_d.wake_d0 = fetch_word[loader_pkg::WAKE_ACTIVE_BIT];
                        state_d.link_mode = fetch_word[loader_pkg::LINK_MODE_MSB:
                                                       loader_pkg::LINK_MODE_LSB];
                    end
                    state_d.done = 1'b1;
                    state_d.fsm = ST_DONE;
                end
            end
            ST_DONE: begin
                // Reload restarts without clearing current settings
                if (reg_write_in && reg_addr_in == loader_pkg::RELOAD_REG_ADDR &&
                    reg_wdata_in[0]) begin
                    state_d.done = 1'b0;
                    state_d.fsm = ST_POWER;
                end
            end
            default: begin
                state_d.fsm = ST_IDLE;
            end
        endcase

        // Crossover decision follows the pair detector only when enabled
        state_d.swap = state_q.auto_cross ? pairs_swapped_in : 1'b0;

        // Wake acts in low power only, or always when the active option is set
        state_d.wake_req = wake_event_in &&
            wake_allowed(state_q.wuc_wake, state_q.wake_d0, low_power_state_in);

        // Register reads answer one cycle later; unmapped reads give zero
        if (reg_read_in) begin
            case (reg_addr_in)
                loader_pkg::STATUS_REG_ADDR: begin
                    state_d.rdata = {13'h0000, state_q.swap, state_q.wake_req, state_q.done};
                end
                loader_pkg::FIELDS_REG_ADDR: begin
                    state_d.rdata = {2'h0, state_q.los_inv, 2'h0, state_q.wuc_wake,
                                     state_q.auto_cross, 1'b0, state_q.rom_dis,
                                     state_q.wake_d0, state_q.link_mode, 4'h0};
                end
                loader_pkg::POWER_WORD_ADDR: begin
                    state_d.rdata = state_q.power_word;
                end
                default: begin
                    state_d.rdata = 16'h0000;
                end
            endcase
        end
    end

    // Reset loads hardware defaults of both words
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.fsm <= ST_IDLE;
            state_q.power_word <= loader_pkg::POWER_WORD_DEFAULT;
            state_q.auto_cross <= loader_pkg::INIT_WORD_DEFAULT[loader_pkg::AUTO_CROSS_BIT];
            state_q.rom_dis <= loader_pkg::INIT_WORD_DEFAULT[loader_pkg::ROM_DISABLE_BIT];
            state_q.link_mode <= loader_pkg::LINK_MODE_COPPER;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Sub blocks
    // ----------------------------------------------------------------
    word_fetch u_fetch (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .start_in(state_q.start),
        .addr_in(state_q.addr),
        .mem_rd_out(mem_rd_out),
        .mem_addr_out(mem_addr_out),
        .mem_data_in(mem_data_in),
        .mem_valid_in(mem_valid_in),
        .done_out(fetch_done),
        .word_out(fetch_word),
        .valid_out(fetch_valid)
    );

    power_data_mux u_power (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .power_word_in(state_q.power_word),
        .data_select_in(data_select_in),
        .power_data_out(power_data_out)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign loss_signal_invert_out = state_q.los_inv;
    assign ctrl_advanced_wake_out = state_q.ctrl_wake;
    assign advanced_wake_enable_out = state_q.wuc_wake;
    assign wake_in_active_state_enable_out = state_q.wake_d0;
    assign auto_crossover_out = state_q.auto_cross;
    assign crossover_swap_out = state_q.swap;
    assign rom_bar_disable_out = state_q.rom_dis;
    assign link_mode_out = state_q.link_mode;
    assign wake_request_out = state_q.wake_req;
    assign load_done_out = state_q.done;
    assign reg_rdata_out = state_q.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_wake_copies: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && fetch_valid |=>
        ctrl_advanced_wake_out == advanced_wake_enable_out &&
        advanced_wake_enable_out == $past(fetch_word[10]))
        else $error("advanced wake copies differ");
    a_los_load: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && fetch_valid |=>
        loss_signal_invert_out == $past(fetch_word[13]))
        else $error("loss invert not loaded");
    a_cross_load: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && fetch_valid |=>
        auto_crossover_out == $past(fetch_word[9]))
        else $error("crossover not loaded");
    a_rom_load: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && fetch_valid |=>
        rom_bar_disable_out == $past(fetch_word[7]) &&
        wake_in_active_state_enable_out == $past(fetch_word[6]))
        else $error("rom disable or wake d0 wrong");
    a_link_load: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && fetch_valid |=>
        link_mode_out == $past(fetch_word[5:4]))
        else $error("link mode not loaded");
    a_blank_keeps: assert property (@(posedge mclk_in) disable iff (!rst_n)
        state_q.fsm == ST_INIT_WAIT && fetch_done && !fetch_valid |=>
        $stable(link_mode_out) && $stable(auto_crossover_out))
        else $error("blank word changed settings");
    a_no_swap_off: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !auto_crossover_out ##1 !$past(auto_crossover_out) |-> !crossover_swap_out)
        else $error("swap while crossover off");
    a_wake_gate: assert property (@(posedge mclk_in) disable iff (!rst_n)
        wake_event_in && advanced_wake_enable_out && !low_power_state_in &&
        !wake_in_active_state_enable_out |=> !wake_request_out)
        else $error("wake in active state not gated");
    a_load_time: assert property (@(posedge mclk_in) disable iff (!rst_n)
        $rose(rst_n) |-> ##[1:12] load_done_out)
        else $error("load did not finish");
    c_load_done: cover property (@(posedge mclk_in) $rose(load_done_out));
    c_wake_req: cover property (@(posedge mclk_in) wake_request_out);
    c_blank_init: cover property (@(posedge mclk_in)
        state_q.fsm == ST_INIT_WAIT && fetch_done && !fetch_valid);
endmodule : power_and_init_word_loader
`default_nettype wire

/* src/loader_pkg.sv */
// Purpose: Constants for the power and init word loader
// Assumes: 16-bit configuration words, 200 MHz core clock
// Notes: Word addresses and field positions of the two loaded words
package loader_pkg;
    // ----------------------------------------------------------------
    // Word addresses in the internal configuration memory
    // ----------------------------------------------------------------
    localparam logic [7:0] POWER_WORD_ADDR = 8'h22;
    localparam logic [7:0] INIT_WORD_ADDR = 8'h24;
    localparam int ADDR_WIDTH = 8;
    localparam int WORD_WIDTH = 16;

    // ----------------------------------------------------------------
    // Power word fields
    // ----------------------------------------------------------------
    localparam int ACTIVE_POWER_MSB = 15;
    localparam int ACTIVE_POWER_LSB = 8;
    localparam int COMMON_POWER_MSB = 7;
    localparam int COMMON_POWER_LSB = 5;
    localparam int LOW_POWER_MSB = 4;
    localparam int LOW_POWER_LSB = 0;

    // ----------------------------------------------------------------
    // Init word fields
    // ----------------------------------------------------------------
    localparam int LOS_INVERT_BIT = 13;
    localparam int ADV_WAKE_BIT = 10;
    localparam int AUTO_CROSS_BIT = 9;
    localparam int ROM_DISABLE_BIT = 7;
    localparam int WAKE_ACTIVE_BIT = 6;
    localparam int LINK_MODE_MSB = 5;
    localparam int LINK_MODE_LSB = 4;

    // ----------------------------------------------------------------
    // Hardware defaults kept when a word is not programmed
    // ----------------------------------------------------------------
    localparam logic [15:0] POWER_WORD_DEFAULT = 16'h0000;
    localparam logic [15:0] INIT_WORD_DEFAULT = 16'h0280;
    localparam logic [1:0] LINK_MODE_COPPER = 2'h0;

    // ----------------------------------------------------------------
    // Data selector codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_ACTIVE_A = 4'h0;
    localparam logic [3:0] SEL_ACTIVE_B = 4'h4;
    localparam logic [3:0] SEL_LOW_A = 4'h3;
    localparam logic [3:0] SEL_LOW_B = 4'h7;
    localparam logic [3:0] SEL_COMMON = 4'h8;

    // ----------------------------------------------------------------
    // Status, fields and reload registers of the loader on the plain port
    // ----------------------------------------------------------------
    localparam logic [7:0] STATUS_REG_ADDR = 8'h00;
    localparam logic [7:0] FIELDS_REG_ADDR = 8'h01;
    localparam logic [7:0] RELOAD_REG_ADDR = 8'h02;
endpackage : loader_pkg

/* src/power_data_mux.sv */
// Purpose: Chooses the power figure that the data register reports
// Assumes: Power word already latched
// Notes: Registered output, one cycle after a selector change
`timescale 1ns/1ps
`default_nettype none
module power_data_mux (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] power_word_in,
    input wire logic [3:0] data_select_in,
    output logic [7:0] power_data_out
);
    typedef struct packed {
        logic [7:0] data;
    } mux_state_type;

    mux_state_type state_q;
    mux_state_type state_d;

    // Field select; narrower fields are zero padded at the top
    always_comb begin
        state_d = state_q;
        case (data_select_in)
            loader_pkg::SEL_ACTIVE_A, loader_pkg::SEL_ACTIVE_B: begin
                state_d.data = power_word_in[loader_pkg::ACTIVE_POWER_MSB:
                                             loader_pkg::ACTIVE_POWER_LSB];
            end
            loader_pkg::SEL_COMMON: begin
                state_d.data = {5'h00, power_word_in[loader_pkg::COMMON_POWER_MSB:
                                                     loader_pkg::COMMON_POWER_LSB]};
            end
            loader_pkg::SEL_LOW_A, loader_pkg::SEL_LOW_B: begin
                state_d.data = {3'h0, power_word_in[loader_pkg::LOW_POWER_MSB:
                                                    loader_pkg::LOW_POWER_LSB]};
            end
            default: begin
                state_d.data = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign power_data_out = state_q.data;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_common_pad: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_select_in == loader_pkg::SEL_COMMON |=> power_data_out[7:3] == 5'h00)
        else $error("common power not zero padded");
    a_active_field: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_select_in == 4'h4 |=> power_data_out == $past(power_word_in[15:8]))
        else $error("active power field wrong");
    a_low_field: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_select_in == 4'h7 |=> power_data_out == {3'h0, $past(power_word_in[4:0])})
        else $error("low power field wrong");
    c_common_sel: cover property (@(posedge mclk_in) data_select_in == 4'h8);
endmodule : power_data_mux
`default_nettype wire

/* src/word_fetch.sv */
// Purpose: Reads one configuration word from the internal memory
// Assumes: Memory answers a read one cycle after the request
// Notes: Read data held in a register until the next fetch
`timescale 1ns/1ps
`default_nettype none
module word_fetch (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [7:0] addr_in,
    output logic mem_rd_out,
    output logic [7:0] mem_addr_out,
    input wire logic [15:0] mem_data_in,
    input wire logic mem_valid_in,
    output logic done_out,
    output logic [15:0] word_out,
    output logic valid_out
);
    typedef struct packed {
        logic rd;
        logic [7:0] addr;
        logic wait_data;
        logic done;
        logic [15:0] word;
        logic valid;
    } fetch_state_type;

    fetch_state_type state_q;
    fetch_state_type state_d;

    // One read, then capture the word and whether it was programmed
    always_comb begin
        state_d = state_q;
        state_d.rd = 1'b0;
        state_d.done = 1'b0;
        if (start_in && !state_q.wait_data) begin
            state_d.rd = 1'b1;
            state_d.addr = addr_in;
            state_d.wait_data = 1'b1;
        end else if (state_q.wait_data && !state_q.rd) begin
            state_d.wait_data = 1'b0;
            state_d.done = 1'b1;
            state_d.word = mem_data_in;
            state_d.valid = mem_valid_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign mem_rd_out = state_q.rd;
    assign mem_addr_out = state_q.addr;
    assign done_out = state_q.done;
    assign word_out = state_q.word;
    assign valid_out = state_q.valid;
endmodule : word_fetch
`default_nettype wire

/* tb/config_memory_model.sv */
// Purpose: Behavioural internal configuration memory for the loader
// Assumes: One-cycle read latency, words 0x22 and 0x24 read only
// Notes: Outside an answer the lines toggle so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module config_memory_model #(
    parameter bit KEEP_PHY_ON = 1'b0
) (
    input wire logic mclk_in,
    input wire logic mem_rd_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic [15:0] power_word_in,
    input wire logic [15:0] init_word_in,
    input wire logic programmed_in,
    output var logic [15:0] mem_data_out = 16'h5A5A,
    output var logic mem_valid_out = 1'b0
);
    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Answer only in the cycle after a request; no hold beyond it
    always @(posedge mclk_in) begin
        if (mem_rd_in && mem_addr_in == loader_pkg::POWER_WORD_ADDR) begin
            mem_data_out <= power_word_in;
            mem_valid_out <= programmed_in;
        end else if (mem_rd_in && mem_addr_in == loader_pkg::INIT_WORD_ADDR) begin
            mem_data_out <= KEEP_PHY_ON ? (init_word_in & 16'hFBFF) : init_word_in;
            mem_valid_out <= programmed_in;
        end else begin
            mem_data_out <= ~mem_data_out;
            mem_valid_out <= ~mem_valid_out;
        end
    end
endmodule : config_memory_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the power and init word loader
// Assumes: 200 MHz clock, memory model with one-cycle latency
// Notes: Random words from a fixed seed; blank word, reload as corners
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic mem_rd, mem_valid, swap, wake_req, done, los, cadv, adv, wd0, ax, rom;
    logic low_power = 1'b0, wake_ev = 1'b0, pairs = 1'b0, prog = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] lmode;
    logic [3:0] sel = 4'h0;
    logic [7:0] mem_addr, pdata, reg_addr = 8'h00;
    logic [15:0] mem_data, rdata, reg_wdata = 16'h0000;
    logic [15:0] pw = 16'h0000, iw = 16'h0000, ew, epw;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [15:0] fields_seen;

    always #2.5 mclk_in = ~mclk_in;

    power_and_init_word_loader power_and_init_word_loader_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .mem_rd_out(mem_rd),
        .mem_addr_out(mem_addr), .mem_data_in(mem_data), .mem_valid_in(mem_valid),
        .data_select_in(sel), .power_data_out(pdata), .low_power_state_in(low_power),
        .wake_event_in(wake_ev), .pairs_swapped_in(pairs), .loss_signal_invert_out(los),
        .ctrl_advanced_wake_out(cadv), .advanced_wake_enable_out(adv),
        .wake_in_active_state_enable_out(wd0), .auto_crossover_out(ax),
        .crossover_swap_out(swap), .rom_bar_disable_out(rom), .link_mode_out(lmode),
        .wake_request_out(wake_req), .load_done_out(done), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_wr), .reg_read_in(reg_rd),
        .reg_rdata_out(rdata));
    config_memory_model config_memory_model_i (
        .mclk_in(mclk_in), .mem_rd_in(mem_rd), .mem_addr_in(mem_addr),
        .power_word_in(pw), .init_word_in(iw), .programmed_in(prog),
        .mem_data_out(mem_data), .mem_valid_out(mem_valid));

    // Loaded settings packed at their init word positions
    assign fields_seen = {2'h0, los, 2'h0, cadv, ax, 1'b0, rom, wd0, lmode, 4'h0};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_power(input logic [3:0] s, input logic [15:0] w);
        case (s)
            4'h0, 4'h4: return w[15:8];
            4'h3, 4'h7: return {3'h0, w[4:0]};
            4'h8: return {5'h00, w[7:5]};
            default: return 8'h00;
        endcase
    endfunction : exp_power
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick
    // Register port: one-cycle strobe, read data stands the cycle after
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk_in);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : reg_access
    // Reset, then wait a bounded time for the automatic load
    task automatic load_words(input logic [15:0] p, input logic [15:0] i, input logic g);
        pw <= p;
        iw <= i;
        prog <= g;
        reset_n_in <= 1'b0;
        tick(10);
        chk({12'h000, ax, rom, lmode}, 16'h000C);
        reset_n_in <= 1'b1;
        for (int k = 0; k < 40 && done !== 1'b1; k++) tick(1);
        chk({15'h0000, done}, 16'h0001);
        ew = g ? i : loader_pkg::INIT_WORD_DEFAULT;
        epw = g ? p : loader_pkg::POWER_WORD_DEFAULT;
    endtask : load_words
    task automatic check_fields();
        chk(fields_seen, ew & 16'h26F0);
        chk({15'h0000, adv}, {15'h0000, ew[10]});
        reg_access(1'b0, loader_pkg::FIELDS_REG_ADDR, 16'h0000);
        chk(rdata, ew & 16'h26F0);
        reg_access(1'b0, loader_pkg::POWER_WORD_ADDR, 16'h0000);
        chk(rdata, epw);
    endtask : check_fields
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // Guard against a hang; the whole run needs well under this
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hA242));
        for (int t = 0; t < 8; t++) begin
            load_words(16'($urandom()), (t == 0) ? 16'hFFFF : 16'($urandom()),
                t != 1 && $urandom_range(3) != 0);
            check_fields();
            for (int s = 0; s < 16; s++) begin
                @(posedge mclk_in);
                sel <= 4'(s);
                tick(2);
                chk({8'h00, pdata}, {8'h00, exp_power(4'(s), epw)});
            end
            repeat (6) begin
                @(posedge mclk_in);
                wake_ev <= 1'($urandom());
                low_power <= 1'($urandom());
                pairs <= 1'($urandom());
                tick(2);
                chk({14'h0000, swap, wake_req}, {14'h0000, ew[9] & pairs,
                    wake_ev & ew[10] & (ew[6] | low_power)});
            end
        end
        // Ignored write, then a reload with contrasting words
        @(posedge mclk_in);
        wake_ev <= 1'b0;
        pairs <= 1'b0;
        pw <= 16'hA5E3;
        iw <= 16'h0440;
        prog <= 1'b1;
        reg_access(1'b1, loader_pkg::FIELDS_REG_ADDR, 16'hFFFF);
        reg_access(1'b1, loader_pkg::RELOAD_REG_ADDR, 16'h0001);
        tick(12);
        ew = 16'h0440;
        epw = 16'hA5E3;
        check_fields();
        reg_access(1'b0, 8'h55, 16'h0000);
        chk(rdata, 16'h0000);
        reg_access(1'b0, loader_pkg::STATUS_REG_ADDR, 16'h0000);
        chk(rdata, 16'h0001);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
